// >>> design/pir_pkg.sv
// Constants and carrier types for the PWM and I2C pin routing block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
package pir_pkg;

  // ****************************************
  // Register map
  // ****************************************
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ROUTE_A  = 8'hb6;
  localparam logic [7:0]  IDX_ROUTE_B  = 8'hb7;
  localparam logic [7:0]  IDX_STATUS   = 8'hc0;
  localparam int          ADDR_W       = 12;
  localparam logic [7:0]  RST_ROUTE_A  = 8'h00;
  localparam logic [7:0]  RST_ROUTE_B  = 8'h00;

  // Route control A bit positions
  localparam int          B_CH4_P00    = 4;
  localparam int          B_CH3_P34    = 3;
  localparam int          B_CH3_P10    = 2;
  localparam int          B_CH2_P36    = 1;
  localparam int          B_CH2_P11    = 0;

  // Route control B bit positions
  localparam int          B_SDA_SEL    = 7;
  localparam int          B_SCL_SEL    = 6;
  localparam int          B_CH6_P13    = 5;
  localparam int          B_CH6_P07    = 4;
  localparam int          B_CH6_P03    = 3;
  localparam int          B_CH5_P14    = 2;
  localparam int          B_CH5_P06    = 1;
  localparam int          B_CH5_P01    = 0;

  // Status bit positions
  localparam int          S_CH2        = 0;
  localparam int          S_CH3        = 1;
  localparam int          S_CH4        = 2;
  localparam int          S_CH5        = 3;
  localparam int          S_CH6        = 4;
  localparam int          S_SDA        = 5;
  localparam int          S_SCL        = 6;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pir_port_t;

  typedef struct packed {
    logic en;
    logic sda_oe;
    logic scl_oe;
  } pir_i2c_drv_t;

  typedef struct packed {
    logic ch6;
    logic ch5;
    logic ch4;
    logic ch3;
    logic ch2;
  } pir_pwm_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_DATA = 2'b10,
    WR_RESP = 2'b11
  } pir_wr_state_t;

endpackage

// >>> design/pir_pin_route.sv
// PWM and I2C pin routing with its AXI4-Lite register slave.
// Assumes PWM levels, port drives and I2C drives come from logic on
// i_sys_clk; pin levels arrive from outside and are synchronised here.
//
// Functional notes
// R1: Route A bit 4 set puts PWM4 onto P0.0, clear disables it.
// R2: Route A bit 3 set puts PWM3 onto P3.4, clear disables it.
// R3: Route A bit 2 set puts PWM3 onto P1.0, clear disables it.
// R4: Route A bit 1 set puts PWM2 onto P3.6, clear disables it.
// R5: Route A bit 0 set puts PWM2 onto P1.1, clear disables it.
// R6: Route B bit 7 picks I2C data pin: 0 P3.5, 1 P1.6.
// R7: Route B bit 6 picks I2C clock pin: 0 P1.3, 1 P0.2.
// R8: Route B bit 5 set puts PWM6 onto P1.3, clear disables it.
// R9: Route B bit 4 set puts PWM6 onto P0.7, clear disables it.
// R10: Route B bit 3 set puts PWM6 onto P0.3, clear disables it.
// R11: Route B bit 2 set puts PWM5 onto P1.4, clear disables it.
// R12: Route B bit 1 set puts PWM5 onto P0.6, clear disables it.
// R13: Route B bit 0 set puts PWM5 onto P0.1, clear disables it.
// R14: Route bits reset to zero; unrouted pins keep ordinary port function.
//
// Register access over AXI4-Lite was chosen for this implementation.
module pir_pin_route (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  // AXI4-Lite slave
  input  wire logic [pir_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [pir_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  // Functional sources
  input  wire pir_pkg::pir_pwm_t          i_pwm,
  input  wire pir_pkg::pir_i2c_drv_t      i_i2c,
  input  wire pir_pkg::pir_port_t         i_p0_gpio,
  input  wire pir_pkg::pir_port_t         i_p1_gpio,
  input  wire pir_pkg::pir_port_t         i_p3_gpio,
  // Pads
  input  wire logic [7:0]                 i_p0_pin,
  input  wire logic [7:0]                 i_p1_pin,
  input  wire logic [7:0]                 i_p3_pin,
  output pir_pkg::pir_port_t              o_p0,
  output pir_pkg::pir_port_t              o_p1,
  output pir_pkg::pir_port_t              o_p3,
  output logic                            o_i2c_sda_in,
  output logic                            o_i2c_scl_in
);

  // ****************************************
  // Helpers
  // ****************************************
  // Byte address of a register index
  function automatic logic [pir_pkg::ADDR_W-1:0] addr_of(
    input logic [7:0] idx
  );
    addr_of = {2'h0, idx, 2'h0};
  endfunction

  // Override one pin bit with a pushed level
  function automatic pir_pkg::pir_port_t drive(
    input pir_pkg::pir_port_t p,
    input int                 bit_n,
    input logic               lvl,
    input logic               oe
  );
    pir_pkg::pir_port_t r;
    r            = p;
    r.out[bit_n] = lvl;
    r.oe[bit_n]  = oe;
    drive        = r;
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]                   route_a_r;
  logic [7:0]                   route_b_r;
  pir_pkg::pir_wr_state_t       wr_state_r;
  pir_pkg::pir_wr_state_t       wr_state_nxt;
  logic [pir_pkg::ADDR_W-1:0]   waddr_r;
  logic [7:0]                   wbyte_r;
  logic                         wlane_r;
  logic [1:0]                   bresp_r;
  logic                         rvalid_r;
  logic [31:0]                  rdata_r;
  logic [1:0]                   rresp_r;
  logic [7:0]                   p0_s1_r;
  logic [7:0]                   p1_s1_r;
  logic [7:0]                   p3_s1_r;
  logic [7:0]                   p0_s2_r;
  logic [7:0]                   p1_s2_r;
  logic [7:0]                   p3_s2_r;
  pir_pkg::pir_port_t           p0_nxt;
  pir_pkg::pir_port_t           p1_nxt;
  pir_pkg::pir_port_t           p3_nxt;
  pir_pkg::pir_port_t           p0_r;
  pir_pkg::pir_port_t           p1_r;
  pir_pkg::pir_port_t           p3_r;
  logic                         sda_in_r;
  logic                         scl_in_r;
  logic [7:0]                   status;
  logic                         aw_hs;
  logic                         w_hs;
  logic                         do_write;
  logic                         ar_hs;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data accepted in either order; response after both
  assign o_awready = i_ce && (wr_state_r == pir_pkg::WR_IDLE
                              || wr_state_r == pir_pkg::WR_DATA);
  assign o_wready  = i_ce && (wr_state_r == pir_pkg::WR_IDLE
                              || wr_state_r == pir_pkg::WR_ADDR);
  assign aw_hs     = i_awvalid && o_awready;
  assign w_hs      = i_wvalid && o_wready;
  // Valid drops while frozen; the master must not see a beat then
  assign o_bvalid  = i_ce && wr_state_r == pir_pkg::WR_RESP;
  assign o_bresp   = bresp_r;

  // Next write state
  always_comb begin
    wr_state_nxt = wr_state_r;
    do_write     = 1'b0;
    case (wr_state_r)
      pir_pkg::WR_IDLE: begin
        if (aw_hs && w_hs) begin
          wr_state_nxt = pir_pkg::WR_RESP;
          do_write     = 1'b1;
        end else if (aw_hs) begin
          wr_state_nxt = pir_pkg::WR_ADDR;
        end else if (w_hs) begin
          wr_state_nxt = pir_pkg::WR_DATA;
        end
      end
      pir_pkg::WR_ADDR: begin
        if (w_hs) begin
          wr_state_nxt = pir_pkg::WR_RESP;
          do_write     = 1'b1;
        end
      end
      pir_pkg::WR_DATA: begin
        if (aw_hs) begin
          wr_state_nxt = pir_pkg::WR_RESP;
          do_write     = 1'b1;
        end
      end
      pir_pkg::WR_RESP: begin
        if (o_bvalid && i_bready) begin
          wr_state_nxt = pir_pkg::WR_IDLE;
        end
      end
      default: wr_state_nxt = pir_pkg::WR_IDLE;
    endcase
  end

  // Write state and captured beats
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_state_r <= pir_pkg::WR_IDLE;
      waddr_r    <= '0;
      wbyte_r    <= 8'h00;
      wlane_r    <= 1'b0;
    end else if (i_ce) begin
      wr_state_r <= wr_state_nxt;
      if (aw_hs) begin
        waddr_r <= i_awaddr;
      end
      if (w_hs) begin
        wbyte_r <= i_wdata[7:0];
        wlane_r <= i_wstrb[0];
      end
    end
  end

  // Effective write address and data, whichever beat came last
  logic [pir_pkg::ADDR_W-1:0] wa;
  logic [7:0]                 wd;
  logic                       wl;
  assign wa = aw_hs ? i_awaddr : waddr_r;
  assign wd = w_hs ? i_wdata[7:0] : wbyte_r;
  assign wl = w_hs ? i_wstrb[0] : wlane_r;

  // R14: reset to zero
  // Route registers; only byte lane 0 carries bits
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      route_a_r <= pir_pkg::RST_ROUTE_A;
      route_b_r <= pir_pkg::RST_ROUTE_B;
      bresp_r   <= pir_pkg::RESP_OKAY;
    end else if (i_ce && do_write) begin
      bresp_r <= pir_pkg::RESP_OKAY;
      if (wa == addr_of(pir_pkg::IDX_ROUTE_A)) begin
        if (wl) begin
          route_a_r <= wd;
        end
      end else if (wa == addr_of(pir_pkg::IDX_ROUTE_B)) begin
        if (wl) begin
          route_b_r <= wd;
        end
      end else if (wa != addr_of(pir_pkg::IDX_STATUS)) begin
        bresp_r <= pir_pkg::RESP_SLVERR;  // Unmapped
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign o_arready = i_ce && !rvalid_r;
  assign ar_hs     = i_arvalid && o_arready;
  assign o_rvalid  = i_ce && rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;

  // Read data captured at address acceptance
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= pir_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rresp_r  <= pir_pkg::RESP_OKAY;
        if (i_araddr == addr_of(pir_pkg::IDX_ROUTE_A)) begin
          rdata_r <= {24'h00_0000, route_a_r};
        end else if (i_araddr == addr_of(pir_pkg::IDX_ROUTE_B)) begin
          rdata_r <= {24'h00_0000, route_b_r};
        end else if (i_araddr == addr_of(pir_pkg::IDX_STATUS)) begin
          rdata_r <= {24'h00_0000, status};
        end else begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= pir_pkg::RESP_SLVERR;
        end
      end else if (i_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  // Two stages before any selection logic sees a pad level
  // Reset high like idle pulled-up lines: no false low after reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      p0_s1_r <= 8'hff;
      p1_s1_r <= 8'hff;
      p3_s1_r <= 8'hff;
      p0_s2_r <= 8'hff;
      p1_s2_r <= 8'hff;
      p3_s2_r <= 8'hff;
    end else if (i_ce) begin
      p0_s1_r <= i_p0_pin;
      p1_s1_r <= i_p1_pin;
      p3_s1_r <= i_p3_pin;
      p0_s2_r <= p0_s1_r;
      p1_s2_r <= p1_s1_r;
      p3_s2_r <= p3_s1_r;
    end
  end

  // ****************************************
  // Output routing
  // ****************************************
  // Port drive by default; PWM routes then I2C override on top.
  // I2C wins on P1.3 so a live bus is never corrupted by PWM6.
  always_comb begin
    p0_nxt = i_p0_gpio;
    p1_nxt = i_p1_gpio;
    p3_nxt = i_p3_gpio;
    // R1: PWM4 to P0.0
    if (route_a_r[pir_pkg::B_CH4_P00]) p0_nxt = drive(p0_nxt, 0, i_pwm.ch4, 1'b1);
    // R2: PWM3 to P3.4
    if (route_a_r[pir_pkg::B_CH3_P34]) p3_nxt = drive(p3_nxt, 4, i_pwm.ch3, 1'b1);
    // R3: PWM3 to P1.0
    if (route_a_r[pir_pkg::B_CH3_P10]) p1_nxt = drive(p1_nxt, 0, i_pwm.ch3, 1'b1);
    // R4: PWM2 to P3.6
    if (route_a_r[pir_pkg::B_CH2_P36]) p3_nxt = drive(p3_nxt, 6, i_pwm.ch2, 1'b1);
    // R5: PWM2 to P1.1
    if (route_a_r[pir_pkg::B_CH2_P11]) p1_nxt = drive(p1_nxt, 1, i_pwm.ch2, 1'b1);
    // R8: PWM6 to P1.3
    if (route_b_r[pir_pkg::B_CH6_P13]) p1_nxt = drive(p1_nxt, 3, i_pwm.ch6, 1'b1);
    // R9: PWM6 to P0.7
    if (route_b_r[pir_pkg::B_CH6_P07]) p0_nxt = drive(p0_nxt, 7, i_pwm.ch6, 1'b1);
    // R10: PWM6 to P0.3
    if (route_b_r[pir_pkg::B_CH6_P03]) p0_nxt = drive(p0_nxt, 3, i_pwm.ch6, 1'b1);
    // R11: PWM5 to P1.4
    if (route_b_r[pir_pkg::B_CH5_P14]) p1_nxt = drive(p1_nxt, 4, i_pwm.ch5, 1'b1);
    // R12: PWM5 to P0.6
    if (route_b_r[pir_pkg::B_CH5_P06]) p0_nxt = drive(p0_nxt, 6, i_pwm.ch5, 1'b1);
    // R13: PWM5 to P0.1
    if (route_b_r[pir_pkg::B_CH5_P01]) p0_nxt = drive(p0_nxt, 1, i_pwm.ch5, 1'b1);
    if (i_i2c.en) begin
      // R6: data pin select
      if (route_b_r[pir_pkg::B_SDA_SEL]) p1_nxt = drive(p1_nxt, 6, 1'b0, i_i2c.sda_oe);
      else                               p3_nxt = drive(p3_nxt, 5, 1'b0, i_i2c.sda_oe);
      // R7: clock pin select
      if (route_b_r[pir_pkg::B_SCL_SEL]) p0_nxt = drive(p0_nxt, 2, 1'b0, i_i2c.scl_oe);
      else                               p1_nxt = drive(p1_nxt, 3, 1'b0, i_i2c.scl_oe);
    end
  end

  // R14: pins released at reset
  // Registered pad drive and I2C line feedback
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      p0_r     <= '0;
      p1_r     <= '0;
      p3_r     <= '0;
      sda_in_r <= 1'b1;
      scl_in_r <= 1'b1;
    end else if (i_ce) begin
      p0_r     <= p0_nxt;
      p1_r     <= p1_nxt;
      p3_r     <= p3_nxt;
      // R6: data line read back
      sda_in_r <= route_b_r[pir_pkg::B_SDA_SEL] ? p1_s2_r[6] : p3_s2_r[5];
      // R7: clock line read back
      scl_in_r <= route_b_r[pir_pkg::B_SCL_SEL] ? p0_s2_r[2] : p1_s2_r[3];
    end
  end

  assign o_p0         = p0_r;
  assign o_p1         = p1_r;
  assign o_p3         = p3_r;
  assign o_i2c_sda_in = sda_in_r;
  assign o_i2c_scl_in = scl_in_r;

  // Status: channel routed anywhere, and the I2C levels seen
  always_comb begin
    status                = 8'h00;
    status[pir_pkg::S_CH2] = route_a_r[pir_pkg::B_CH2_P36] | route_a_r[pir_pkg::B_CH2_P11];
    status[pir_pkg::S_CH3] = route_a_r[pir_pkg::B_CH3_P34] | route_a_r[pir_pkg::B_CH3_P10];
    status[pir_pkg::S_CH4] = route_a_r[pir_pkg::B_CH4_P00];
    status[pir_pkg::S_CH5] = |route_b_r[pir_pkg::B_CH5_P14:pir_pkg::B_CH5_P01];
    status[pir_pkg::S_CH6] = |route_b_r[pir_pkg::B_CH6_P13:pir_pkg::B_CH6_P03];
    status[pir_pkg::S_SDA] = sda_in_r;
    status[pir_pkg::S_SCL] = scl_in_r;
  end

endmodule

// >>> bench/pir_pin_route_chk.sv
// Checker: pad drive against shadow copies of the route registers.
// Assumes the master offers write address and data in the same cycle.
module pir_pin_route_chk (
  input wire logic                       i_sys_clk,
  input wire logic                       i_rst_n,
  input wire logic [pir_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic                       i_awvalid,
  input wire logic                       o_awready,
  input wire logic [31:0]                i_wdata,
  input wire logic [3:0]                 i_wstrb,
  input wire logic                       i_wvalid,
  input wire logic                       o_wready,
  input wire pir_pkg::pir_pwm_t          i_pwm,
  input wire pir_pkg::pir_i2c_drv_t      i_i2c,
  input wire pir_pkg::pir_port_t         i_p0_gpio,
  input wire pir_pkg::pir_port_t         o_p0,
  input wire pir_pkg::pir_port_t         o_p1,
  input wire pir_pkg::pir_port_t         o_p3
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_ADR = {2'h0, pir_pkg::IDX_ROUTE_A, 2'h0};
  localparam logic [11:0] B_ADR = {2'h0, pir_pkg::IDX_ROUTE_B, 2'h0};
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic       wr_go;
  // Shadow routes; a split address/data write is not tracked
  assign wr_go = i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb[0];
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
    end else if (wr_go && i_awaddr == A_ADR) begin
      sh_a <= i_wdata[7:0];
    end else if (wr_go && i_awaddr == B_ADR) begin
      sh_b <= i_wdata[7:0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // Pads follow routes one cycle late
  // ****
  ch4_route_a: assert property ($past(sh_a[4]) |->
    o_p0.oe[0] && o_p0.out[0] == $past(i_pwm.ch4)) else $error("PWM4 off P0.0");
  ch3_route_a: assert property ($past(sh_a[3]) |->
    o_p3.oe[4] && o_p3.out[4] == $past(i_pwm.ch3)) else $error("PWM3 off P3.4");
  ch2_route_a: assert property ($past(sh_a[0]) |->
    o_p1.oe[1] && o_p1.out[1] == $past(i_pwm.ch2)) else $error("PWM2 off P1.1");
  sda_pick_a: assert property ($past(i_rst_n && i_i2c.en && i_i2c.sda_oe) |->
    ($past(sh_b[7]) ? o_p1.oe[6] && !o_p1.out[6] : o_p3.oe[5] && !o_p3.out[5]))
    else $error("data line on wrong pin");
  scl_pick_a: assert property ($past(i_rst_n && i_i2c.en && i_i2c.scl_oe) |->
    ($past(sh_b[6]) ? o_p0.oe[2] && !o_p0.out[2] : o_p1.oe[3] && !o_p1.out[3]))
    else $error("clock line on wrong pin");
  ch6_route_a: assert property ($past(sh_b[5] && !(i_i2c.en && !sh_b[6])) |->
    o_p1.oe[3] && o_p1.out[3] == $past(i_pwm.ch6)) else $error("PWM6 off P1.3");
  ch5_route_a: assert property ($past(sh_b[1]) |->
    o_p0.oe[6] && o_p0.out[6] == $past(i_pwm.ch5)) else $error("PWM5 off P0.6");
  idle_pin_a: assert property ($past(i_rst_n && !sh_a[4]) |->
    o_p0.oe[0] == $past(i_p0_gpio.oe[0]) && o_p0.out[0] == $past(i_p0_gpio.out[0]))
    else $error("P0.0 lost port drive");
endmodule

bind pir_pin_route pir_pin_route_chk u_chk (
  .i_sys_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
  .i_wvalid, .o_wready, .i_pwm, .i_i2c, .i_p0_gpio, .o_p0, .o_p1, .o_p3
);

// >>> bench/pir_pin_partner.sv
// Far-side model: PWM generators and port pads with pull-ups.
// Assumes the block's port outputs are the only drivers of the pads.
module pir_pin_partner (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire pir_pkg::pir_port_t i_p0,
  input  wire pir_pkg::pir_port_t i_p1,
  input  wire pir_pkg::pir_port_t i_p3,
  output pir_pkg::pir_pwm_t       o_pwm,
  output logic [7:0]              o_p0_pin,
  output logic [7:0]              o_p1_pin,
  output logic [7:0]              o_p3_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  // Free counter; each channel toggles at its own rate
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign o_pwm = {cnt_r[0], cnt_r[1], cnt_r[2], cnt_r[3], cnt_r[4]};
  // Released pads float high, so a stale level never shows
  assign o_p0_pin = (i_p0.oe & i_p0.out) | ~i_p0.oe;
  assign o_p1_pin = (i_p1.oe & i_p1.out) | ~i_p1.oe;
  assign o_p3_pin = (i_p3.oe & i_p3.out) | ~i_p3.oe;
endmodule

// >>> bench/pwm_i2c_pin_routing_tb_top.sv
// Testbench: AXI4-Lite tasks and pin routing scenarios.
// Assumes the far-side model drives PWM and pad levels.
module pwm_i2c_pin_routing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0]        A_ADR = {2'h0, pir_pkg::IDX_ROUTE_A, 2'h0};
  localparam logic [11:0]        B_ADR = {2'h0, pir_pkg::IDX_ROUTE_B, 2'h0};
  localparam logic [11:0]        S_ADR = {2'h0, pir_pkg::IDX_STATUS, 2'h0};
  localparam logic [23:0]        G_OE  = 24'h8fa430;
  localparam pir_pkg::pir_port_t P0_G  = {8'h5a, 8'h30};
  localparam pir_pkg::pir_port_t P1_G  = {8'hc3, 8'ha4};
  localparam pir_pkg::pir_port_t P3_G  = {8'h69, 8'h8f};
  logic                  i_sys_clk, i_rst_n, i_awvalid, i_wvalid, i_bready;
  logic                  i_arvalid, i_rready, o_awready, o_wready, o_bvalid;
  logic                  o_arready, o_rvalid, o_i2c_sda_in, o_i2c_scl_in;
  logic [11:0]           i_awaddr, i_araddr;
  logic [31:0]           i_wdata, o_rdata;
  logic [3:0]            i_wstrb;
  logic [1:0]            o_bresp, o_rresp;
  logic [7:0]            i_p0_pin, i_p1_pin, i_p3_pin;
  pir_pkg::pir_pwm_t     i_pwm;
  pir_pkg::pir_i2c_drv_t i_i2c;
  pir_pkg::pir_port_t    o_p0, o_p1, o_p3;
  int                    num_errors, cmp_count, k;
  int                    pin_of [11] = '{9, 22, 8, 20, 0, 1, 6, 12, 3, 7, 11};

  pir_pin_route dut (
    .i_sys_clk, .i_rst_n, .i_ce(1'b1), .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pwm, .i_i2c,
    .i_p0_gpio(P0_G), .i_p1_gpio(P1_G), .i_p3_gpio(P3_G), .i_p0_pin, .i_p1_pin,
    .i_p3_pin, .o_p0, .o_p1, .o_p3, .o_i2c_sda_in, .o_i2c_scl_in
  );
  pir_pin_partner u_far (
    .i_sys_clk, .i_rst_n, .i_p0(o_p0), .i_p1(o_p1), .i_p3(o_p3), .o_pwm(i_pwm),
    .o_p0_pin(i_p0_pin), .o_p1_pin(i_p1_pin), .o_p3_pin(i_p3_pin)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write; address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] br;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge i_sys_clk);
      aw_ok = i_awvalid && o_awready;
      w_ok = i_wvalid && o_wready;
      b_ok = o_bvalid;
      br = o_bresp;
      @(posedge i_sys_clk);
      if (aw_ok) i_awvalid <= 1'b0;
      if (w_ok) i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
    chk({30'h0, br}, {30'h0, er});
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok, r_ok;
    logic [31:0] rd;
    logic [1:0] rr;
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge i_sys_clk);
      ar_ok = i_arvalid && o_arready;
      r_ok = o_rvalid;
      rd = o_rdata;
      rr = o_rresp;
      @(posedge i_sys_clk);
      if (ar_ok) i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
    chk(rd, ed);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  task automatic pads(input logic [23:0] exp);
    @(negedge i_sys_clk);
    chk({8'h00, o_p3.oe, o_p1.oe, o_p0.oe}, {8'h00, exp});
  endtask

  task automatic give_verdict;
    $display("errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    {i_awaddr, i_araddr, i_wdata, i_i2c} = '0;
    i_wstrb = 4'hf;
    num_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    axr(A_ADR, 32'h0, pir_pkg::RESP_OKAY);
    axr(B_ADR, 32'h0, pir_pkg::RESP_OKAY);
    pads(G_OE);
    chk({8'h00, o_p3.out, o_p1.out, o_p0.out}, 32'h0069c35a);
    // One route bit at a time, all others clear
    for (k = 0; k < 11; k++) begin
      axw(k < 5 ? A_ADR : B_ADR, 8'h01 << (k < 5 ? k : k - 5), pir_pkg::RESP_OKAY);
      pads(G_OE | (24'h1 << pin_of[k]));
      // Route A cleared before the B bits, so each check sees one route only
      if (k == 4) axw(A_ADR, 8'h00, pir_pkg::RESP_OKAY);
    end
    // Every data and clock pin choice with the master pulling low
    @(posedge i_sys_clk);
    i_i2c <= 3'b111;
    for (k = 0; k < 4; k++) begin
      axw(B_ADR, {k[1:0], 6'h00}, pir_pkg::RESP_OKAY);
      pads(G_OE | (24'h1 << (k[1] ? 14 : 21)) | (24'h1 << (k[0] ? 2 : 11)));
    end
    repeat (4) @(negedge i_sys_clk);
    chk({31'h0, o_i2c_sda_in}, 32'h0);
    chk({31'h0, o_i2c_scl_in}, 32'h0);
    @(posedge i_sys_clk);
    i_i2c <= 3'b000;
    axw(12'h100, 8'hff, pir_pkg::RESP_SLVERR);
    axr(12'h100, 32'h0, pir_pkg::RESP_SLVERR);
    axw(A_ADR, 8'he5, pir_pkg::RESP_OKAY);
    axr(A_ADR, 32'he5, pir_pkg::RESP_OKAY);
    // Lane 0 strobe low: answered, nothing stored
    i_wstrb <= 4'he;
    axw(A_ADR, 8'h00, pir_pkg::RESP_OKAY);
    i_wstrb <= 4'hf;
    axr(A_ADR, 32'he5, pir_pkg::RESP_OKAY);
    // Status ignores writes; PWM2 and PWM3 routed, both I2C pads idle high
    axw(S_ADR, 8'hff, pir_pkg::RESP_OKAY);
    axr(S_ADR, 32'h63, pir_pkg::RESP_OKAY);
    // Reset in mid-run clears the routes again
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    axr(A_ADR, 32'h0, pir_pkg::RESP_OKAY);
    pads(G_OE);
    axr(S_ADR, 32'h60, pir_pkg::RESP_OKAY);
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
